// ==== hdl/srg_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Reset high while main supply is low
// - Power-up holds reset for selected timeout
// - Timeout chosen by two control bits
// - Manual reset input high forces reset
// - Reset held timeout after manual release
// - Second fail follows second comparator level
// - No timeout applied to second fail
// - Third fail follows third comparator, no timeout
// - Write-protect high refuses nonvolatile writes
// - Protect plus nonzero lock refuses all writes
// - Write-protect reads as low only from reset until the pin has passed both sync stages
module srg_top #(
  parameter logic [31:0] timeout0_cyc = srg_pkg::timeout0_cycles,
  parameter logic [31:0] timeout1_cyc = srg_pkg::timeout1_cycles,
  parameter logic [31:0] timeout2_cyc = srg_pkg::timeout2_cycles,
  parameter logic [31:0] timeout3_cyc = srg_pkg::timeout3_cycles
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Comparator and pin inputs
  input wire logic i_supply_ok,
  input wire logic i_second_monitor_in,
  input wire logic i_third_monitor_in,
  input wire logic i_manual_reset_in,
  input wire logic i_write_protect,
  // Avalon-MM slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Supervisor outputs
  output logic o_main_reset,
  output logic o_second_fail_out,
  output logic o_third_fail_out,
  // Write gate outputs
  output logic o_nv_write_ok,
  output logic o_vol_write_ok
);
  logic [4:0] pin_raw;
  logic [4:0] pin_sync;
  logic supply_ok;
  logic second_in;
  logic third_in;
  logic manual_in;
  logic protect_in;
  logic trigger;
  logic [3:0] ctrl_q;
  logic [31:0] count_q;
  logic [31:0] limit;
  srg_pkg::srg_state_type state_q;
  logic [1:0] wres_q;
  logic bus_done_q;
  logic nv_ok;
  logic vol_ok;
  logic refuse;
  logic [31:0] status_word;

  // Two-stage synchroniser per pin; only the second stage is read
  assign pin_raw = {i_write_protect, i_manual_reset_in, i_third_monitor_in,
                    i_second_monitor_in, i_supply_ok};
  for (genvar b = 0; b < 5; b++)
  begin : g_sync
    logic stage1_q;
    logic stage2_q;
    always_ff @(posedge i_clock or posedge i_reset)
    begin
      if (i_reset)
      begin
        stage1_q <= 1'b0;
        stage2_q <= 1'b0;
      end
      else
      begin
        stage1_q <= pin_raw[b];
        stage2_q <= stage1_q;
      end
    end
    assign pin_sync[b] = stage2_q;
  end

  assign supply_ok = pin_sync[0];
  assign second_in = pin_sync[1];
  assign third_in = pin_sync[2];
  assign manual_in = pin_sync[3];
  // Reset clears the sync chain; protect reads low only until the pin has passed both stages
  assign protect_in = pin_sync[4];
  // Either cause restarts the whole timeout
  assign trigger = ~supply_ok | manual_in;

  // Timeout select; a new select applies to a count in progress
  always_comb
  begin
    case ({ctrl_q[srg_pkg::timeout_select_bit1_pos],
           ctrl_q[srg_pkg::timeout_select_bit0_pos]})
      2'b00: limit = timeout0_cyc;
      2'b01: limit = timeout1_cyc;
      2'b10: limit = timeout2_cyc;
      default: limit = timeout3_cyc;
    endcase
  end

  // Reset sequencer; starts held so power-up runs a full timeout
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q <= srg_pkg::srg_held;
      count_q <= 32'h0000_0000;
      o_main_reset <= 1'b1;
    end
    else
    begin
      case (state_q)
        srg_pkg::srg_held:
        begin
          o_main_reset <= 1'b1;
          count_q <= 32'h0000_0000;
          if (!trigger)
          begin
            state_q <= srg_pkg::srg_run;
          end
        end
        srg_pkg::srg_run:
        begin
          if (trigger)
          begin
            // Retrigger throws away the partial count
            state_q <= srg_pkg::srg_held;
            count_q <= 32'h0000_0000;
            o_main_reset <= 1'b1;
          end
          else if (count_q + 32'h0000_0001 >= limit)
          begin
            state_q <= srg_pkg::srg_free;
            o_main_reset <= 1'b0;
            count_q <= 32'h0000_0000;
          end
          else
          begin
            count_q <= count_q + 32'h0000_0001;
            o_main_reset <= 1'b1;
          end
        end
        // Once released, a later select write must not reassert reset
        srg_pkg::srg_free:
        begin
          count_q <= 32'h0000_0000;
          if (trigger)
          begin
            state_q <= srg_pkg::srg_held;
            o_main_reset <= 1'b1;
          end
          else
          begin
            o_main_reset <= 1'b0;
          end
        end
        default:
        begin
          state_q <= srg_pkg::srg_held;
          o_main_reset <= 1'b1;
        end
      endcase
    end
  end

  // Fail outputs carry the synchroniser latency plus one register stage
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_second_fail_out <= 1'b0;
      o_third_fail_out <= 1'b0;
    end
    else
    begin
      o_second_fail_out <= second_in;
      o_third_fail_out <= third_in;
    end
  end

  // Write gating; registered so the gate outputs cannot glitch
  assign nv_ok = ~protect_in;
  assign vol_ok = ~(protect_in & (ctrl_q[srg_pkg::lock_lo_pos] |
                  ctrl_q[srg_pkg::lock_hi_pos]));

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_nv_write_ok <= 1'b1;
      o_vol_write_ok <= 1'b1;
    end
    else
    begin
      o_nv_write_ok <= nv_ok & vol_ok;
      o_vol_write_ok <= vol_ok;
    end
  end

  // Bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      bus_done_q <= 1'b0;
      o_waitrequest <= 1'b1;
    end
    else if ((i_read | i_write) && !bus_done_q)
    begin
      bus_done_q <= 1'b1;
      o_waitrequest <= 1'b0;
    end
    else
    begin
      bus_done_q <= 1'b0;
      o_waitrequest <= 1'b1;
    end
  end

  // Control register; write takes effect when waitrequest is low
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      ctrl_q <= srg_pkg::ctrl_reset;
    end
    else if (i_write && !o_waitrequest && i_address == srg_pkg::ctrl_off)
    begin
      // Locking lives here too; a locked, protected part refuses it
      if (vol_ok)
      begin
        ctrl_q <= i_writedata[3:0];
      end
    end
  end

  // Nonvolatile needs both gates; protect plus lock blocks everything
  always_comb
  begin
    refuse = 1'b0;
    if (i_writedata[srg_pkg::wreq_nv_pos] && !(nv_ok && vol_ok))
    begin
      refuse = 1'b1;
    end
    if (i_writedata[srg_pkg::wreq_vol_pos] && !vol_ok)
    begin
      refuse = 1'b1;
    end
  end

  // Write request check: software asks, block answers granted or refused
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      wres_q <= 2'h0;
    end
    else if (i_write && !o_waitrequest && i_address == srg_pkg::wreq_off)
    begin
      // Result holds until the next request
      wres_q[srg_pkg::wres_granted_pos] <= ~refuse;
      wres_q[srg_pkg::wres_refused_pos] <= refuse;
    end
  end

  // Status bits placed by their field positions
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[srg_pkg::st_reset_pos] = o_main_reset;
    status_word[srg_pkg::st_second_pos] = o_second_fail_out;
    status_word[srg_pkg::st_third_pos] = o_third_fail_out;
    status_word[srg_pkg::st_protect_pos] = protect_in;
  end

  // Read data registered alongside the handshake
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_readdata <= 32'h0000_0000;
    end
    else if (i_read && !bus_done_q)
    begin
      case (i_address)
        srg_pkg::ctrl_off: o_readdata <= {28'h0000000, ctrl_q};
        srg_pkg::status_off: o_readdata <= status_word;
        // Request register is write-only
        srg_pkg::wreq_off: o_readdata <= 32'h0000_0000;
        srg_pkg::wres_off: o_readdata <= {30'h00000000, wres_q};
        default: o_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== hdl/srg_pkg.sv ====
package srg_pkg;
  // Register byte offsets
  localparam logic [3:0] ctrl_off = 4'h0;
  localparam logic [3:0] status_off = 4'h4;
  localparam logic [3:0] wreq_off = 4'h8;
  localparam logic [3:0] wres_off = 4'hc;
  // Control register fields
  localparam int timeout_select_bit0_pos = 0;
  localparam int timeout_select_bit1_pos = 1;
  localparam int lock_lo_pos = 2;
  localparam int lock_hi_pos = 3;
  localparam logic [3:0] ctrl_reset = 4'h0;
  // Status register fields
  localparam int st_reset_pos = 0;
  localparam int st_second_pos = 1;
  localparam int st_third_pos = 2;
  localparam int st_protect_pos = 3;
  // Write request fields: bit0 nonvolatile, bit1 volatile
  localparam int wreq_nv_pos = 0;
  localparam int wreq_vol_pos = 1;
  // Write result fields
  localparam int wres_granted_pos = 0;
  localparam int wres_refused_pos = 1;
  // Reset timeout choices, microseconds
  localparam longint timeout0_us = 64'd50;
  localparam longint timeout1_us = 64'd100;
  localparam longint timeout2_us = 64'd200;
  localparam longint timeout3_us = 64'd400;
  localparam longint clock_mhz = 64'd125;
  localparam logic [31:0] timeout0_cycles = 32'(timeout0_us * clock_mhz);
  localparam logic [31:0] timeout1_cycles = 32'(timeout1_us * clock_mhz);
  localparam logic [31:0] timeout2_cycles = 32'(timeout2_us * clock_mhz);
  localparam logic [31:0] timeout3_cycles = 32'(timeout3_us * clock_mhz);
  typedef enum logic [2:0] {
    srg_held = 3'b001,
    srg_run = 3'b010,
    srg_free = 3'b100
  } srg_state_type;
endpackage

// ==== tb/srg_monitor.sv ====
`timescale 1ns/1ps
module srg_monitor #(
  parameter logic [31:0] timeout0_cyc = 32'h8
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_supply_ok,
  input wire logic i_second_monitor_in,
  input wire logic i_third_monitor_in,
  input wire logic i_manual_reset_in,
  input wire logic i_write_protect,
  input wire logic o_main_reset,
  input wire logic o_second_fail_out,
  input wire logic o_third_fail_out,
  input wire logic o_nv_write_ok,
  input wire logic o_vol_write_ok
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  logic [31:0] quiet_q;
  // Counts at the pin; the design lags it, so the bound is safe
  always_ff @(posedge i_clock or posedge i_reset)
    if (i_reset || !i_supply_ok || i_manual_reset_in)
      quiet_q <= 32'h0;
    else
      quiet_q <= quiet_q + 32'h1;
  sequence s_low; !i_supply_ok[*3]; endsequence
  sequence s_up2; $rose(i_second_monitor_in) ##1 i_second_monitor_in[*2];
  endsequence
  property p_low; s_low |=> o_main_reset; endproperty
  a_low: assert property (p_low) else $error("no reset");
  property p_man; i_manual_reset_in[*3] |=> o_main_reset; endproperty
  a_man: assert property (p_man) else $error("no manual reset");
  property p_hold;
    $fell(o_main_reset) |-> $past(quiet_q, 2) >= timeout0_cyc;
  endproperty
  a_hold: assert property (p_hold) else $error("early");
  property p_sec_lo; !i_second_monitor_in[*3] |=> !o_second_fail_out;
  endproperty
  a_sec_lo: assert property (p_sec_lo) else $error("fail2 high");
  property p_sec_up; s_up2 |=> o_second_fail_out; endproperty
  a_sec_up: assert property (p_sec_up) else $error("fail2 late");
  property p_third;
    $stable(i_third_monitor_in)[*3] |=>
      o_third_fail_out == $past(i_third_monitor_in);
  endproperty
  a_third: assert property (p_third) else $error("fail3");
  property p_nv; i_write_protect[*3] |=> !o_nv_write_ok; endproperty
  a_nv: assert property (p_nv) else $error("nv open");
  property p_vol; !i_write_protect[*3] |=> o_vol_write_ok; endproperty
  a_vol: assert property (p_vol) else $error("vol shut");
  property p_keep; !o_main_reset && quiet_q > 32'h3 |=> !o_main_reset;
  endproperty
  a_keep: assert property (p_keep) else $error("reset rose");
endmodule
bind srg_top srg_monitor #(.timeout0_cyc(timeout0_cyc)) srg_monitor_i (
  .i_clock, .i_reset, .i_supply_ok, .i_second_monitor_in,
  .i_third_monitor_in, .i_manual_reset_in, .i_write_protect,
  .o_main_reset, .o_second_fail_out, .o_third_fail_out, .o_nv_write_ok,
  .o_vol_write_ok);

// ==== tb/srg_host_model.sv ====
`timescale 1ns/1ps
module srg_host_model (
  input wire logic i_clock,
  input wire logic i_main_reset,
  output logic [15:0] o_pulse_len
);
  logic [15:0] run_q = 16'h0;
  // Host times each reset pulse it is given
  always_ff @(posedge i_clock)
    if (i_main_reset)
      run_q <= run_q + 16'h1;
    else if (run_q != 16'h0)
    begin
      o_pulse_len <= run_q;
      run_q <= 16'h0;
    end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_supply_ok = 1'b0;
  logic i_second_monitor_in = 1'b0;
  logic i_third_monitor_in = 1'b0;
  logic i_manual_reset_in = 1'b0;
  logic i_write_protect = 1'b0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [3:0] i_address = 4'h0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata, rd;
  logic o_waitrequest, o_main_reset, o_second_fail_out, o_third_fail_out;
  logic o_nv_write_ok, o_vol_write_ok;
  logic [15:0] pulse_len;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  logic [31:0] lim [4] = '{32'h8, 32'h10, 32'h18, 32'h20};
  always #4 i_clock = ~i_clock;
  srg_top #(.timeout0_cyc(32'h8), .timeout1_cyc(32'h10),
    .timeout2_cyc(32'h18), .timeout3_cyc(32'h20)) srg_top_i (.i_clock,
    .i_reset, .i_supply_ok, .i_second_monitor_in, .i_third_monitor_in,
    .i_manual_reset_in, .i_write_protect, .i_address, .i_read, .i_write,
    .i_writedata, .o_readdata, .o_waitrequest, .o_main_reset,
    .o_second_fail_out, .o_third_fail_out, .o_nv_write_ok, .o_vol_write_ok);
  srg_host_model srg_host_model_i (.i_clock, .i_main_reset(o_main_reset),
    .o_pulse_len(pulse_len));
  task automatic summarize;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge i_clock);
  endtask
  // Held until waitrequest is seen low; one idle edge after release
  task automatic bus(input logic wr, logic [3:0] a, logic [31:0] d);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    if (o_waitrequest !== 1'b0)
    begin
      miscompares++;
      summarize();
    end
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    tick(1);
  endtask
  // Window allows for the synchroniser stages
  task automatic hold(input logic [31:0] l);
    n = 0;
    while (o_main_reset !== 1'b0 && n < 200)
    begin
      tick(1);
      n++;
    end
    chk("hold", 32'(n >= l && n < l + 8), 32'h1);
  endtask
  initial
  begin
    tick(20);
    i_reset <= 1'b0;
    tick(5);
    chk("rst", o_main_reset, 1'b1);
    bus(0, srg_pkg::ctrl_off, 32'h0);
    chk("ctrl", rd, 32'(srg_pkg::ctrl_reset));
    bus(0, 4'h2, 32'h0);
    chk("unmap", rd, 32'h0);
    i_supply_ok <= 1'b1;
    hold(lim[0]);
    for (int s = 0; s < 4; s++)
    begin
      bus(1, srg_pkg::ctrl_off, 32'(s));
      tick(1);
      chk("keep", o_main_reset, 1'b0);
      i_manual_reset_in <= 1'b1;
      tick(4);
      chk("mr", o_main_reset, 1'b1);
      i_manual_reset_in <= 1'b0;
      hold(lim[s]);
    end
    tick(2);
    chk("pulse", 32'(pulse_len > 16'h20 && pulse_len < 16'h29),
      32'h1);
    bus(1, srg_pkg::ctrl_off, 32'h0);
    i_manual_reset_in <= 1'b1;
    tick(4);
    i_manual_reset_in <= 1'b0;
    tick(5);
    i_supply_ok <= 1'b0;
    tick(2);
    i_supply_ok <= 1'b1;
    hold(lim[0]);
    for (int v = 1; v >= 0; v--)
    begin
      i_supply_ok <= !v[0];
      i_second_monitor_in <= v[0];
      i_third_monitor_in <= v[0];
      tick(4);
      chk("f2", o_second_fail_out, v[0]);
      chk("f3", o_third_fail_out, v[0]);
      chk("rst", o_main_reset, 1'b1);
    end
    tick(20);
    chk("nv", o_nv_write_ok, 1'b1);
    i_write_protect <= 1'b1;
    tick(4);
    chk("nv", o_nv_write_ok, 1'b0);
    bus(0, srg_pkg::status_off, 32'h0);
    chk("status", rd, 32'h1 << srg_pkg::st_protect_pos);
    bus(1, srg_pkg::wreq_off, 32'h1);
    bus(0, srg_pkg::wres_off, 32'h0);
    chk("wres", rd, 32'h2);
    for (int k = 1; k < 4; k++)
    begin
      i_write_protect <= 1'b0;
      tick(4);
      bus(1, srg_pkg::wreq_off, 32'h3);
      bus(0, srg_pkg::wres_off, 32'h0);
      chk("grant", rd, 32'h1);
      bus(1, srg_pkg::ctrl_off, 32'(k << 2));
      i_write_protect <= 1'b1;
      tick(4);
      chk("vol", o_vol_write_ok, 1'b0);
      bus(1, srg_pkg::wreq_off, 32'h2);
      bus(0, srg_pkg::wres_off, 32'h0);
      chk("volreq", rd, 32'h2);
      bus(1, srg_pkg::ctrl_off, 32'h0);
      bus(0, srg_pkg::ctrl_off, 32'h0);
      chk("ctrl", rd, 32'(k << 2));
    end
    summarize();
  end
endmodule
